// ### core/tmc_pkg.sv
package tmc_pkg;

  // ----------------------------------------------------------------
  // Serial access map
  // ----------------------------------------------------------------
  localparam logic [3:0] CTRL_ADDR = 4'h4;
  localparam logic [3:0] STAT_ADDR = 4'h5;
  localparam logic [5:0] WORD_BITS = 6'h20;
  localparam logic [2:0] ADDR_BITS = 3'h4;

  // ----------------------------------------------------------------
  // Main control word layout and reset value
  // ----------------------------------------------------------------
  localparam logic [31:0] CTRL_RESET = 32'h10000270;
  // Reserved bits 10, 3, 2 and 0 are held at zero
  localparam logic [31:0] CTRL_WRITABLE = 32'hfffffbf2;
  localparam int unsigned PWR_BIT = 31;
  localparam int unsigned DIR_BIT = 30;
  localparam int unsigned RCLK_BIT = 29;
  localparam int unsigned LOCKONLY_BIT = 28;
  localparam int unsigned PA_BIT = 27;
  localparam int unsigned WAKE_BIT = 26;
  localparam int unsigned LNA_BIT = 25;
  localparam int unsigned MSUP_BIT = 24;
  localparam int unsigned THR_LSB = 18;
  localparam int unsigned HYS_LSB = 15;
  localparam int unsigned TRANSMIT_POWER_LEVEL_LSB = 12;
  localparam int unsigned TRANSMIT_FREQ_PAIR_SELECT_BIT = 11;
  localparam int unsigned RECEIVE_FREQ_SELECT_LSB = 8;
  localparam int unsigned XTAL_BIT = 7;
  localparam int unsigned DISC_BIT = 6;
  localparam int unsigned POL_BIT = 5;
  localparam int unsigned SREF_BIT = 4;
  localparam int unsigned ADCSRC_BIT = 1;
  localparam int unsigned THR_W = 6;
  localparam int unsigned HYS_W = 3;

  // ----------------------------------------------------------------
  // Status word layout, 31 bits sent MSB first
  // ----------------------------------------------------------------
  localparam int unsigned STAT_LOCK_BIT = 30;
  localparam int unsigned STAT_STRENGTH_LSB = 16;
  localparam int unsigned STAT_SUPPLY_LSB = 8;

  // ----------------------------------------------------------------
  // Serial engine states, Gray code order idle-addr-write-read
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TMC_IDLE = 2'b00,
    TMC_ADDR = 2'b01,
    TMC_WRITE = 2'b11,
    TMC_READ = 2'b10
  } tmc_state_type;

endpackage

// ### core/tmc_strength_gate.sv
`timescale 1ns/10ps
module tmc_strength_gate import tmc_pkg::*; #(
  parameter int unsigned W = 6
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [W-1:0] strength,
  input wire logic [W-1:0] threshold,
  input wire logic [HYS_W-1:0] hysteresis,
  output logic valid_q
);

  // ----------------------------------------------------------------
  // Elaboration check
  // ----------------------------------------------------------------
  if (W < HYS_W || W > 16) begin : g_bad_w
    $error("strength width out of range");
  end

  logic valid_d;
  logic [W:0] high_lvl;
  logic signed [W+1:0] low_lvl;

  // High level one bit wider, low level two bits wider and signed, so neither wraps
  always_comb begin
    high_lvl = {1'b0, threshold} + (W+1)'(hysteresis);
    low_lvl = $signed({2'b00, threshold}) - $signed((W+2)'(hysteresis));
    valid_d = valid_q;
    if ({1'b0, strength} >= high_lvl) begin
      valid_d = 1'b1;
    end else if ($signed({2'b00, strength}) < low_lvl) begin
      valid_d = 1'b0;
    end
  end

  // Between the levels the last decision stands
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      valid_q <= 1'b0;
    end else begin
      valid_q <= valid_d;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  valid_high_a: assert property (@(posedge sys_clk) disable iff (rst)
    ({1'b0, strength} >= high_lvl) |=> valid_q)
    else $error("data not validated above high level");
  valid_low_a: assert property (@(posedge sys_clk) disable iff (rst)
    ($signed({2'b00, strength}) < low_lvl) |=> !valid_q)
    else $error("data not inhibited below low level");
  valid_hold_a: assert property (@(posedge sys_clk) disable iff (rst)
    ({1'b0, strength} < high_lvl
     && $signed({2'b00, strength}) >= low_lvl) |=> $stable(valid_q))
    else $error("validation changed inside hysteresis band");

endmodule

// ### core/tmc_core.sv
`timescale 1ns/10ps
// Functional notes
// - Power field 0 powers down all but serial
// - Direction: 0 receive, 1 transmit, receive after reset
// - Clock recovery pin silent unless enabled
// - Lock-only field gates transmit on PLL lock
// - PLL lock reported in status register bit
// - Amplifier on only with enable and power on
// - Wake-up disabled while enable field is 0
// - Gain select: 0 maximum, 1 minimum
// - Measure select: 0 strength, 1 supply
// - Data valid with threshold plus/minus hysteresis
// - Three-bit transmit level, 000 min, 111 max
// - Transmit select 0 uses codes 0 and 1
// - Receive select picks code 0..3, reset 10
// - Crystal select: 0 lower, 1 higher reference
// - Discriminator range: 0 narrow, 1 standard
// - Data polarity: 0 inverted, 1 direct
// - Slicer reference: 0 filter pin, 1 internal
// - Converter source: 0 supply, 1 discriminator level
// - Supply measurement freezes last strength value
// - No supply measurement in power-down
module tmc_core import tmc_pkg::*; (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic sle_n,
  input wire logic sck,
  input wire logic sdata_i,
  output logic sdata_o,
  output logic sdata_oe,
  input wire logic pll_lock,
  input wire logic rec_clk_raw,
  input wire logic rx_demod,
  input wire logic radio_data_pin_i,
  output logic radio_data_pin_o,
  output logic radio_data_pin_oe,
  input wire logic adc_valid,
  input wire logic [THR_W-1:0] adc_value,
  output logic chip_active,
  output logic tx_mode,
  output logic tx_enable,
  output logic tx_mod_data,
  output logic amplifier_on,
  output logic wakeup_on,
  output logic low_noise_gain_min,
  output logic adc_measure_supply,
  output logic adc_source_disc,
  output logic [2:0] transmit_power_level,
  output logic [1:0] tx_code_first,
  output logic [1:0] tx_code_second,
  output logic [1:0] receive_freq_select,
  output logic crystal_select,
  output logic discriminator_range,
  output logic slicer_reference_select,
  output logic recovered_clock_pin
);

  // ----------------------------------------------------------------
  // Pin synchronisers, first stage read only by the second
  // ----------------------------------------------------------------
  logic [5:0] sync_m_q;
  logic [5:0] sync_s_q;
  logic sle_p_q;
  logic sck_p_q;
  logic sle_n_s, sck_s, sdata_s, lock_s, rclk_s, demod_s, rdata_s;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      sync_m_q <= 6'h3f;
      sync_s_q <= 6'h3f;
      sle_p_q <= 1'b1;
      sck_p_q <= 1'b1;
    end else begin
      sync_m_q <= {sle_n, sck, sdata_i, pll_lock, rec_clk_raw, rx_demod};
      sync_s_q <= sync_m_q;
      sle_p_q <= sle_n_s;
      sck_p_q <= sck_s;
    end
  end

  assign {sle_n_s, sck_s, sdata_s, lock_s, rclk_s, demod_s} = sync_s_q;

  logic rdata_m_q, rdata_s_q;

  // Transmit data pin has its own pair, it idles low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      rdata_m_q <= 1'b0;
      rdata_s_q <= 1'b0;
    end else begin
      rdata_m_q <= radio_data_pin_i;
      rdata_s_q <= rdata_m_q;
    end
  end

  assign rdata_s = rdata_s_q;

  logic acc_start, acc_stop, sck_rise, sck_fall;
  assign acc_start = sle_p_q && !sle_n_s;
  assign acc_stop = !sle_p_q && sle_n_s;
  assign sck_rise = !sck_p_q && sck_s && !sle_n_s;
  assign sck_fall = sck_p_q && !sck_s && !sle_n_s;

  // ----------------------------------------------------------------
  // Serial engine
  // ----------------------------------------------------------------
  tmc_state_type state_q, state_d;
  logic [3:0] addr_q, addr_d;
  logic [5:0] cnt_q, cnt_d;
  logic [31:0] wbuf_q, wbuf_d;
  logic [31:0] mask_q, mask_d;
  logic done_q, done_d;
  logic [31:0] rd_word_q, rd_word_d;
  logic sdo_q, sdo_d, sdoe_q, sdoe_d;
  logic [31:0] ctrl_q, ctrl_d;
  logic [THR_W-1:0] strength_q, strength_d;
  logic [THR_W-1:0] supply_q, supply_d;
  logic lock_stat_q;
  logic [30:0] stat_word;
  logic commit;
  logic [4:0] widx;
  logic meas_supply;

  assign meas_supply = ctrl_q[MSUP_BIT] && ctrl_q[PWR_BIT];

  always_comb begin
    stat_word = '0;
    stat_word[STAT_LOCK_BIT] = lock_stat_q;
    stat_word[STAT_STRENGTH_LSB +: THR_W] = strength_q;
    stat_word[STAT_SUPPLY_LSB +: THR_W] = supply_q;
  end

  // Sequence and shift; an overlong write commits on its extra edge
  always_comb begin
    state_d = state_q;
    addr_d = addr_q;
    cnt_d = cnt_q;
    wbuf_d = wbuf_q;
    mask_d = mask_q;
    done_d = done_q;
    rd_word_d = rd_word_q;
    sdo_d = sdo_q;
    sdoe_d = sdoe_q;
    commit = 1'b0;
    widx = 5'h1f - cnt_q[4:0];
    if (acc_stop || sle_n_s) begin
      commit = acc_stop && state_q == TMC_WRITE && !done_q;
      state_d = TMC_IDLE;
      sdoe_d = 1'b0;
      sdo_d = 1'b0;
    end else if (acc_start) begin
      state_d = TMC_ADDR;
      cnt_d = '0;
      mask_d = '0;
      done_d = 1'b0;
    end else begin
      unique case (state_q)
        TMC_IDLE: begin
          state_d = TMC_IDLE;
        end
        TMC_ADDR: begin
          if (sck_rise && cnt_q < 6'(ADDR_BITS)) begin
            addr_d = {addr_q[2:0], sdata_s};
            cnt_d = cnt_q + 6'h01;
          end else if (sck_rise) begin
            cnt_d = '0;
            wbuf_d = ctrl_q;
            if (sdata_s) begin
              state_d = TMC_WRITE;
            end else begin
              state_d = TMC_READ;
              // Unknown address streams ones, then zeros
              if (addr_q == CTRL_ADDR) begin
                rd_word_d = ctrl_q;
              end else if (addr_q == STAT_ADDR) begin
                rd_word_d = {stat_word, 1'b0};
              end else begin
                rd_word_d = 32'hffffffff;
              end
            end
          end
        end
        TMC_WRITE: begin
          if (sck_rise && cnt_q < WORD_BITS) begin
            wbuf_d[widx] = sdata_s;
            mask_d[widx] = 1'b1;
            cnt_d = cnt_q + 6'h01;
          end else if (sck_rise && !done_q) begin
            commit = 1'b1;
            done_d = 1'b1;
          end
        end
        TMC_READ: begin
          // Zero fill past the word clamps the line low
          if (sck_fall) begin
            sdoe_d = 1'b1;
            sdo_d = rd_word_q[31];
            rd_word_d = {rd_word_q[30:0], 1'b0};
          end
        end
      endcase
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      state_q <= TMC_IDLE;
      addr_q <= '0;
      cnt_q <= '0;
      wbuf_q <= '0;
      mask_q <= '0;
      done_q <= 1'b0;
      rd_word_q <= '0;
      sdo_q <= 1'b0;
      sdoe_q <= 1'b0;
    end else begin
      state_q <= state_d;
      addr_q <= addr_d;
      cnt_q <= cnt_d;
      wbuf_q <= wbuf_d;
      mask_q <= mask_d;
      done_q <= done_d;
      rd_word_q <= rd_word_d;
      sdo_q <= sdo_d;
      sdoe_q <= sdoe_d;
    end
  end

  // ----------------------------------------------------------------
  // Control word and measurements
  // ----------------------------------------------------------------
  // Only the bits shifted in change; reserved bits stay zero
  always_comb begin
    ctrl_d = ctrl_q;
    if (commit && addr_q == CTRL_ADDR) begin
      ctrl_d = ((ctrl_q & ~mask_q) | (wbuf_q & mask_q))
               & CTRL_WRITABLE;
    end
    strength_d = strength_q;
    supply_d = supply_q;
    if (adc_valid && ctrl_q[PWR_BIT]) begin
      if (meas_supply) begin
        supply_d = adc_value;
      end else begin
        strength_d = adc_value;
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ctrl_q <= CTRL_RESET;
      strength_q <= '0;
      supply_q <= '0;
      lock_stat_q <= 1'b0;
    end else begin
      ctrl_q <= ctrl_d;
      strength_q <= strength_d;
      supply_q <= supply_d;
      lock_stat_q <= lock_s;
    end
  end

  logic data_valid;

  tmc_strength_gate #(.W(THR_W)) u_gate (
    .sys_clk(sys_clk),
    .rst(rst),
    .strength(strength_q),
    .threshold(ctrl_q[THR_LSB +: THR_W]),
    .hysteresis(ctrl_q[HYS_LSB +: HYS_W]),
    .valid_q(data_valid)
  );

  // ----------------------------------------------------------------
  // Registered outputs to the radio
  // ----------------------------------------------------------------
  logic pwr, rx_drive, tx_go;
  logic [31:0] out_d, out_q;

  assign pwr = ctrl_q[PWR_BIT];
  assign rx_drive = pwr && !ctrl_q[DIR_BIT];
  assign tx_go = pwr && ctrl_q[DIR_BIT]
                 && (!ctrl_q[LOCKONLY_BIT] || lock_s);

  // Powered-down chip keeps every radio function off
  always_comb begin
    out_d = '0;
    out_d[0] = pwr;
    out_d[1] = ctrl_q[DIR_BIT];
    out_d[2] = tx_go;
    out_d[3] = tx_go && rdata_s;
    out_d[4] = ctrl_q[PA_BIT] && pwr;
    out_d[5] = ctrl_q[WAKE_BIT] && pwr;
    out_d[6] = ctrl_q[LNA_BIT];
    out_d[7] = meas_supply;
    out_d[8] = ctrl_q[ADCSRC_BIT];
    out_d[11:9] = ctrl_q[TRANSMIT_POWER_LEVEL_LSB +: 3];
    // Pair select 0 gives codes 0/1, 1 gives codes 2/3
    out_d[13:12] = {ctrl_q[TRANSMIT_FREQ_PAIR_SELECT_BIT], 1'b0};
    out_d[15:14] = {ctrl_q[TRANSMIT_FREQ_PAIR_SELECT_BIT], 1'b1};
    out_d[17:16] = ctrl_q[RECEIVE_FREQ_SELECT_LSB +: 2];
    out_d[18] = ctrl_q[XTAL_BIT];
    out_d[19] = ctrl_q[DISC_BIT];
    out_d[20] = ctrl_q[SREF_BIT];
    out_d[21] = pwr && ctrl_q[RCLK_BIT] && rclk_s;
    // Inhibited data reads low; polarity 0 inverts
    out_d[22] = rx_drive && data_valid
                && (ctrl_q[POL_BIT] ? demod_s : !demod_s);
    out_d[23] = rx_drive;
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      out_q <= '0;
    end else begin
      out_q <= out_d;
    end
  end

  assign sdata_o = sdo_q;
  assign sdata_oe = sdoe_q;
  assign chip_active = out_q[0];
  assign tx_mode = out_q[1];
  assign tx_enable = out_q[2];
  assign tx_mod_data = out_q[3];
  assign amplifier_on = out_q[4];
  assign wakeup_on = out_q[5];
  assign low_noise_gain_min = out_q[6];
  assign adc_measure_supply = out_q[7];
  assign adc_source_disc = out_q[8];
  assign transmit_power_level = out_q[11:9];
  assign tx_code_first = out_q[13:12];
  assign tx_code_second = out_q[15:14];
  assign receive_freq_select = out_q[17:16];
  assign crystal_select = out_q[18];
  assign discriminator_range = out_q[19];
  assign slicer_reference_select = out_q[20];
  assign recovered_clock_pin = out_q[21];
  assign radio_data_pin_o = out_q[22];
  assign radio_data_pin_oe = out_q[23];

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence wr_close_s;
    state_q == TMC_WRITE && !done_q && addr_q == CTRL_ADDR && acc_stop;
  endsequence

  reset_word_a: assert property (@(posedge sys_clk)
    $fell(rst) |-> ctrl_q == CTRL_RESET && !chip_active)
    else $error("control word not at reset value");
  write_merge_a: assert property (wr_close_s |=>
    (ctrl_q & $past(mask_q)) == ($past(wbuf_q & mask_q) & CTRL_WRITABLE))
    else $error("written bits not committed");
  amp_gate_a: assert property (amplifier_on |->
    $past(ctrl_q[PA_BIT]) && $past(ctrl_q[PWR_BIT]))
    else $error("amplifier on without enable and power");
  tx_lock_a: assert property (tx_enable && $past(ctrl_q[LOCKONLY_BIT])
    |-> $past(lock_s))
    else $error("transmit enabled without lock");
  rclk_off_a: assert property (!$past(ctrl_q[RCLK_BIT])
    |-> !recovered_clock_pin)
    else $error("recovered clock driven while disabled");
  supply_pd_a: assert property (adc_valid && !pwr |=>
    $stable(supply_q) && $stable(strength_q))
    else $error("measurement taken in power-down");
  rssi_hold_a: assert property (adc_valid && meas_supply |=>
    $stable(strength_q))
    else $error("strength changed during supply measurement");
  rx_dir_a: assert property (radio_data_pin_oe |->
    !$past(ctrl_q[DIR_BIT]) && $past(pwr))
    else $error("data pin driven outside receive");
  lock_stat_a: assert property ($rose(lock_s) |=>
    stat_word[STAT_LOCK_BIT])
    else $error("lock state not reported");

endmodule

// ### dv/tmc_host_model.sv
`timescale 1ns/10ps
// ----------------------------------------------------------------
// Microcontroller on the three-wire serial port
// ----------------------------------------------------------------
module tmc_host_model (
  input wire logic sys_clk,
  input wire logic sdata_o,
  input wire logic sdata_oe,
  output logic sle_n,
  output logic sck,
  output logic sdata_wire,
  output logic rd_stb,
  output logic [31:0] rd_word
);
  logic drv_en;
  logic drv_bit;
  logic noise_q;

  // Idle levels; serial clock stands low outside frames
  initial begin
    sle_n = 1'b1;
    sck = 1'b0;
    drv_en = 1'b0;
    drv_bit = 1'b0;
    rd_stb = 1'b0;
    rd_word = 32'h0;
    noise_q = 1'b0;
  end

  // Released line toggles so a stale bit never reads as valid
  always @(posedge sys_clk) begin
    noise_q <= ~noise_q;
  end
  assign sdata_wire = sdata_oe ? sdata_o : (drv_en ? drv_bit : noise_q);

  // Wait a number of falling system clock edges
  task automatic half(input int c);
    repeat (c) @(negedge sys_clk);
  endtask

  // One serial period: low four cycles, high four cycles
  task automatic clk_bit(input logic b, input logic drive);
    sck = 1'b0;
    drv_en = drive;
    drv_bit = b;
    half(4);
    sck = 1'b1;
    half(4);
  endtask

  // One access: header, then n data bits MSB first
  task automatic xfer(input logic [3:0] a, input logic wr, input int n,
                      input logic [31:0] d);
    logic [4:0] hdr;
    hdr = {a, wr};
    rd_word = 32'h0;
    sle_n = 1'b0;
    half(3);
    for (int i = 4; i >= 0; i--) begin
      clk_bit(hdr[i], 1'b1);
    end
    for (int i = 0; i < n; i++) begin
      clk_bit(d[31-i], wr);
      // Sampled late in the high phase, long after the device settles
      if (!wr) begin
        rd_word = {rd_word[30:0], sdata_wire};
      end
    end
    sck = 1'b0;
    drv_en = 1'b0;
    half(4);
    sle_n = 1'b1;
    half(1);
    rd_stb = ~wr;
    half(1);
    rd_stb = 1'b0;
    half(6);
  endtask
endmodule

// ### dv/tb_tmc_core.sv
`timescale 1ns/10ps
module tb_tmc_core import tmc_pkg::*; ;
  logic sys_clk, rst, sle_n, sck, sdata_line, sdata_o, sdata_oe;
  logic pll_lock, rec_clk_raw, rx_demod, rpin, tx_bit;
  logic radio_data_pin_o, radio_data_pin_oe, adc_valid;
  logic [5:0] adc_value;
  logic chip_active, tx_mode, tx_enable, tx_mod_data, amplifier_on;
  logic wakeup_on, low_noise_gain_min, adc_measure_supply, adc_source_disc;
  logic [2:0] transmit_power_level;
  logic [1:0] tx_code_first, tx_code_second, receive_freq_select;
  logic crystal_select, discriminator_range, slicer_reference_select;
  logic recovered_clock_pin, rd_stb;
  logic [31:0] rd_word, w;
  logic [19:0] obs, e;
  logic [31:0] exp_q [$];
  logic [5:0] seq [10];
  logic [9:0] vexp;
  int n_mismatch = 0;
  int checks_done = 0;

  // Clock, pin resolution and output snapshot
  initial sys_clk = 1'b0;
  always #50 sys_clk = ~sys_clk;
  assign rpin = radio_data_pin_oe ? radio_data_pin_o : tx_bit;
  assign obs = {chip_active, tx_mode, tx_enable, amplifier_on, wakeup_on,
    low_noise_gain_min, adc_measure_supply, adc_source_disc,
    transmit_power_level, tx_code_first, tx_code_second,
    receive_freq_select, crystal_select, discriminator_range,
    slicer_reference_select};

  tmc_core tmc_core_inst (.sys_clk(sys_clk), .rst(rst), .sle_n(sle_n),
    .sck(sck), .sdata_i(sdata_line), .sdata_o(sdata_o),
    .sdata_oe(sdata_oe), .pll_lock(pll_lock), .rec_clk_raw(rec_clk_raw),
    .rx_demod(rx_demod), .radio_data_pin_i(rpin),
    .radio_data_pin_o(radio_data_pin_o),
    .radio_data_pin_oe(radio_data_pin_oe), .adc_valid(adc_valid),
    .adc_value(adc_value), .chip_active(chip_active), .tx_mode(tx_mode),
    .tx_enable(tx_enable), .tx_mod_data(tx_mod_data),
    .amplifier_on(amplifier_on), .wakeup_on(wakeup_on),
    .low_noise_gain_min(low_noise_gain_min),
    .adc_measure_supply(adc_measure_supply),
    .adc_source_disc(adc_source_disc),
    .transmit_power_level(transmit_power_level),
    .tx_code_first(tx_code_first), .tx_code_second(tx_code_second),
    .receive_freq_select(receive_freq_select),
    .crystal_select(crystal_select),
    .discriminator_range(discriminator_range),
    .slicer_reference_select(slicer_reference_select),
    .recovered_clock_pin(recovered_clock_pin));

  tmc_host_model host_inst (.sys_clk(sys_clk), .sdata_o(sdata_o),
    .sdata_oe(sdata_oe), .sle_n(sle_n), .sck(sck),
    .sdata_wire(sdata_line), .rd_stb(rd_stb), .rd_word(rd_word));

  // ----------------------------------------------------------------
  // Checking helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp,
                       input string what);
    checks_done++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t %s: seen %h expected %h", $time, what, seen, exp);
    end
  endtask

  task automatic finish_test();
    $display("checks_done=%0d n_mismatch=%0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Expected outputs from a control word and the lock level
  function automatic logic [19:0] exp_out(input logic [31:0] v,
                                          input logic lk);
    logic p;
    p = v[PWR_BIT];
    return {p, v[DIR_BIT], p & v[DIR_BIT] & (~v[LOCKONLY_BIT] | lk),
      p & v[PA_BIT], p & v[WAKE_BIT], v[LNA_BIT], p & v[MSUP_BIT],
      v[ADCSRC_BIT], v[TRANSMIT_POWER_LEVEL_LSB+:3], v[TRANSMIT_FREQ_PAIR_SELECT_BIT], 1'b0, v[TRANSMIT_FREQ_PAIR_SELECT_BIT],
      1'b1, v[RECEIVE_FREQ_SELECT_LSB+:2], v[XTAL_BIT], v[DISC_BIT], v[SREF_BIT]};
  endfunction

  // Oldest noted read result against each finished read
  always @(posedge sys_clk) begin
    if (rd_stb === 1'b1) begin
      if (exp_q.size() == 0) begin
        n_mismatch++;
        $display("[FAIL] %0t unexpected read", $time);
      end else begin
        check(rd_word, exp_q.pop_front(), "read");
      end
    end
  end

  task automatic rd(input logic [3:0] a, input int n, input logic [31:0] x);
    exp_q.push_back(x);
    host_inst.xfer(a, 1'b0, n, 32'h0);
  endtask

  task automatic wr(input logic [31:0] v);
    host_inst.xfer(CTRL_ADDR, 1'b1, 32, v);
  endtask

  task automatic adc(input logic [5:0] v);
    adc_value = v;
    adc_valid = 1'b1;
    @(negedge sys_clk);
    adc_valid = 1'b0;
    repeat (6) @(negedge sys_clk);
  endtask

  // Hang guard: a run past its budget is a mismatch
  initial begin
    repeat (90000) @(posedge sys_clk);
    n_mismatch++;
    $display("[FAIL] %0t run did not finish", $time);
    finish_test();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    rst = 1'b1;
    pll_lock = 1'b0;
    rec_clk_raw = 1'b0;
    rx_demod = 1'b0;
    tx_bit = 1'b0;
    adc_valid = 1'b0;
    adc_value = 6'h0;
    void'($urandom(62880));
    repeat (2) @(negedge sys_clk);
    rst = 1'b0;
    repeat (3) @(negedge sys_clk);
    check(32'(obs), 32'(exp_out(CTRL_RESET, 1'b0)), "reset");
    rd(CTRL_ADDR, 32, CTRL_RESET);
    $display("test reset done");

    // Random words, both power states, random radio-side pins
    for (int k = 0; k < 8; k++) begin
      w = $urandom() & CTRL_WRITABLE;
      w[PWR_BIT] = k[0];
      wr(w);
      pll_lock = 1'($urandom());
      rec_clk_raw = 1'($urandom());
      tx_bit = 1'($urandom());
      repeat (6) @(negedge sys_clk);
      e = exp_out(w, pll_lock);
      check(32'(obs), 32'(e), "fields");
      check({29'h0, tx_mod_data, recovered_clock_pin, radio_data_pin_oe},
        {29'h0, e[17] & tx_bit, rec_clk_raw & w[RCLK_BIT] & w[PWR_BIT],
        w[PWR_BIT] & ~w[DIR_BIT]}, "pins");
      rd(CTRL_ADDR, 32, w);
    end
    $display("test fields done");

    // Partial write, ignored write, invalid address
    host_inst.xfer(CTRL_ADDR, 1'b1, 2, 32'h80000000);
    w = {2'b10, w[29:0]};
    rd(CTRL_ADDR, 32, w);
    host_inst.xfer(4'h6, 1'b1, 32, 32'hffffffff);
    rd(CTRL_ADDR, 32, w);
    rd(4'h7, 32, 32'hffffffff);
    $display("test access done");

    // Strength gate with hysteresis, threshold 32 and hysteresis 4 (levels 36 and 28)
    seq = '{6'h1b, 6'h20, 6'h23, 6'h24, 6'h23, 6'h20, 6'h1d, 6'h1c, 6'h1b,
      6'h19};
    vexp = 10'b0001111100;
    w = CTRL_RESET | 32'h80000000 | (32'h20 << THR_LSB) | (32'h4 << HYS_LSB);
    wr(w);
    rx_demod = 1'b1;
    for (int k = 0; k < 10; k++) begin
      adc(seq[k]);
      check(32'(radio_data_pin_o), 32'(vexp[9-k]), "gate");
    end
    adc(6'h28);
    check(32'(radio_data_pin_o), 32'h1, "direct");
    w[POL_BIT] = 1'b0;
    wr(w);
    check(32'(radio_data_pin_o), 32'h0, "inverted");
    rx_demod = 1'b0;
    repeat (6) @(negedge sys_clk);
    check(32'(radio_data_pin_o), 32'h1, "inverted");
    $display("test gate done");

    // Status word: lock, strength, supply, power-down freeze
    pll_lock = 1'b1;
    repeat (6) @(negedge sys_clk);
    rd(STAT_ADDR, 31, 32'h40280000);
    w = w | 32'h40000000 | 32'h01000000;
    wr(w);
    adc(6'h11);
    rd(STAT_ADDR, 31, 32'h40281100);
    w[PWR_BIT] = 1'b0;
    wr(w);
    adc(6'h05);
    rd(STAT_ADDR, 31, 32'h40281100);
    $display("test status done");
    finish_test();
  end
endmodule
